// ### hw/rate_timer.sv
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module rate_timer (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // apb slave
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic            pready,
  output logic [31:0]     prdata,
  output logic            pslverr,
  // serial shift logic
  input  wire logic       rx_active,
  input  wire logic       tx_shift_empty,
  output logic            rate_tick,
  output logic            sync_mode,
  output logic            port_enable
);
  import rate_timer_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]  div_low_r;
  logic [7:0]  div_high_r;
  logic [7:0]  tx_ctrl_r;
  logic [7:0]  rx_ctrl_r;
  logic [7:0]  baud_ctl_r;
  logic [15:0] count_r;
  logic [5:0]  pre_r;
  logic        rx_busy_s1_r;
  logic        rx_busy_s2_r;
  logic        tx_empty_s1_r;
  logic        tx_empty_s2_r;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire access_w  = psel & penable;
  wire wr_w      = access_w & pwrite;
  wire rd_w      = access_w & ~pwrite;
  wire hit_lo    = (paddr == ADDR_DIV_LOW);
  wire hit_hi    = (paddr == ADDR_DIV_HIGH);
  wire hit_tx    = (paddr == ADDR_TX_CTRL);
  wire hit_rx    = (paddr == ADDR_RX_CTRL);
  wire hit_bc    = (paddr == ADDR_BAUD_CTL);
  wire mapped    = hit_lo | hit_hi | hit_tx | hit_rx | hit_bc;
  wire div_write = wr_w & (hit_lo | hit_hi);

  // ----------------------------------------------------------------
  // mode selection
  // ----------------------------------------------------------------
  wire sync_sel  = tx_ctrl_r[MODE_SYNC_BIT];
  wire wide_sel  = baud_ctl_r[WIDE_DIV_BIT];
  wire fast_sel  = tx_ctrl_r[HIGH_SPEED_BIT] & ~sync_sel;
  wire [15:0] divisor = wide_sel ? {div_high_r, div_low_r} : {8'h00, div_low_r};
  wire [5:0] pre_top = sync_sel              ? PRE_4 :
                       (wide_sel &  fast_sel) ? PRE_4 :
                       (wide_sel & ~fast_sel) ? PRE_16 :
                       (fast_sel)             ? PRE_16 :
                                                PRE_64;
  wire pre_done   = (pre_r >= pre_top);
  wire count_done = pre_done & (count_r >= divisor);
  wire rx_idle    = ~rx_busy_s2_r;

  wire [7:0] baud_rd = {1'b0, rx_idle, baud_ctl_r[5:0] & BAUD_CTL_WMASK[5:0]};
  wire [7:0] tx_rd   = {tx_ctrl_r[7:2], tx_empty_s2_r, tx_ctrl_r[0]};
  wire [7:0] rd_mux  = hit_lo ? div_low_r :
                       hit_hi ? div_high_r :
                       hit_tx ? tx_rd :
                       hit_rx ? rx_ctrl_r :
                       hit_bc ? baud_rd : 8'h00;

  // ----------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_busy_s1_r  <= 1'b0;
      rx_busy_s2_r  <= 1'b0;
      tx_empty_s1_r <= 1'b1;
      tx_empty_s2_r <= 1'b1;
    end else begin
      rx_busy_s1_r  <= rx_active;
      rx_busy_s2_r  <= rx_busy_s1_r;
      tx_empty_s1_r <= tx_shift_empty;
      tx_empty_s2_r <= tx_empty_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_low_r  <= DIV_RST;
      div_high_r <= DIV_RST;
      tx_ctrl_r  <= TX_CTRL_RST;
      rx_ctrl_r  <= RX_CTRL_RST;
      baud_ctl_r <= BAUD_CTL_RST;
    end else if (wr_w) begin
      if (hit_lo) div_low_r <= pwdata[7:0];
      if (hit_hi) div_high_r <= pwdata[7:0];
      if (hit_tx) tx_ctrl_r <= pwdata[7:0] & TX_CTRL_WMASK;
      if (hit_rx) rx_ctrl_r <= pwdata[7:0];
      if (hit_bc) baud_ctl_r <= pwdata[7:0] & BAUD_CTL_WMASK;
    end
  end

  // ----------------------------------------------------------------
  // free-running rate timer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_r   <= 6'h00;
      count_r <= 16'h0000;
    end else if (div_write) begin
      pre_r   <= 6'h00;
      count_r <= 16'h0000;
    end else if (pre_done) begin
      pre_r   <= 6'h00;
      count_r <= count_done ? 16'h0000 : count_r + 16'h0001;
    end else begin
      pre_r   <= pre_r + 6'h01;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rate_tick <= 1'b0;
    end else begin
      rate_tick <= count_done & ~div_write;
    end
  end

  // ----------------------------------------------------------------
  // apb answer and mode outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable & ~pready;
      pslverr <= psel & ~penable & ~pready & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite) ? {24'h000000, rd_mux} : prdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_mode   <= 1'b0;
      port_enable <= 1'b0;
    end else begin
      sync_mode   <= sync_sel;
      port_enable <= rx_ctrl_r[7];
    end
  end

  wire unused_rd = rd_w;

endmodule
`default_nettype wire

// ### pkg/rate_timer_pkg.sv
// What this block does
// - the rate timer serves both serial modes and runs 8-bit after reset, 16-bit only when wide_divisor_select is set.
// - the timer runs freely, its period set by the divisor pair as one value, only the low byte in 8-bit operation.
// - asynchronously the multiplier follows high_speed_select and wide_divisor_select; synchronously high_speed_select is ignored.
// - a write to either divisor byte clears the running timer so the new rate starts at once.
// - async, 8-bit, low speed gives the oscillator over 64 times divisor plus one.
// - async, 16-bit, low speed gives the oscillator over 16 times divisor plus one.
// - synchronous operation gives the oscillator over 4 times divisor plus one for either width.
// - the receiver idle flag reads 1 while idle and 0 once a start bit begins a reception.
// - the mode select bit picks synchronous when 1 and asynchronous when 0.
package rate_timer_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DIV_LOW  = 8'h00;
  localparam logic [7:0] ADDR_DIV_HIGH = 8'h04;
  localparam logic [7:0] ADDR_TX_CTRL  = 8'h08;
  localparam logic [7:0] ADDR_RX_CTRL  = 8'h0c;
  localparam logic [7:0] ADDR_BAUD_CTL = 8'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MODE_SYNC_BIT  = 4;
  localparam int HIGH_SPEED_BIT = 2;
  localparam int TX_EMPTY_BIT   = 1;
  localparam int WIDE_DIV_BIT   = 3;
  localparam int RX_IDLE_BIT    = 6;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] TX_CTRL_RST  = 8'h02;
  localparam logic [7:0] RX_CTRL_RST  = 8'h00;
  localparam logic [7:0] BAUD_CTL_RST = 8'h40;
  localparam logic [7:0] DIV_RST      = 8'h00;

  // ----------------------------------------------------------------
  // prescale top counts (one less than the oscillator cycles per timer step)
  // ----------------------------------------------------------------
  localparam logic [5:0] PRE_64 = 6'h3f;
  localparam logic [5:0] PRE_16 = 6'h0f;
  localparam logic [5:0] PRE_4  = 6'h03;

  // writable masks per register
  localparam logic [7:0] TX_CTRL_WMASK  = 8'hfd;
  localparam logic [7:0] BAUD_CTL_WMASK = 8'h3b;

endpackage

// ### verif/rate_timer_chk.sv
`timescale 1ns/10ps
`default_nettype none
module rate_timer_chk (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        rate_tick,
  input wire logic        sync_mode,
  input wire logic        port_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire setup = psel && !penable;
  wire acc   = psel && penable && pwrite;
  a_ready_after_setup: assert property (setup |=> pready) else $error("no ready");
  a_ready_single: assert property (pready |=> !pready) else $error("long ready");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits");
  a_unmapped_err: assert property (setup && paddr == 8'h14 |=> pslverr) else $error("no slverr");
  a_unmapped_keep: assert property (acc && paddr == 8'h14 |=> $stable(sync_mode))
    else $error("unmapped write landed");
  a_mode_select: assert property (acc && paddr == 8'h08 |-> ##2 sync_mode == $past(pwdata[4], 2))
    else $error("mode bit");
  a_port_enable: assert property (acc && paddr == 8'h0c |-> ##2 port_enable == $past(pwdata[7], 2))
    else $error("enable bit");
  a_write_restart: assert property (acc && paddr == 8'h00 |=> ##1 !rate_tick[*2])
    else $error("tick after restart");
  a_tick_gap: assert property (rate_tick |=> !rate_tick[*3]) else $error("tick gap");
  cover property (acc && paddr == 8'h00);
  cover property (rate_tick && sync_mode);
  cover property (pready && pslverr);
endmodule
bind rate_timer rate_timer_chk u_chk (.*);
`default_nettype wire

// ### verif/rate_timer_test.sv
`timescale 1ns/10ps
`default_nettype none
module rate_timer_test;
  logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, rx_start = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, rate_tick, sync_mode, port_enable, rx_active, tx_shift_empty, err;
  logic [2:0] cfg [6] = '{3'b000, 3'b010, 3'b001, 3'b011, 3'b110, 3'b101};
  int num_errors = 0, num_checks = 0, cyc = 0, c, p, i;
  always #20 clk = ~clk;
  rate_timer DUT (.*);
  serial_far_end far (.*);
  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task tick();
    c = 0;
    do begin @(posedge clk); c++; end while (rate_tick !== 1'b1 && c < 9000);
  endtask
  task report_and_stop();
    if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin num_errors++; report_and_stop(); end
  end
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1;
    apb(0, 8'h08, 0); check(rd, 8'h02);
    apb(0, 8'h10, 0); check(rd, 8'h40);
    apb(0, 8'h00, 0); check(rd, 0);
    apb(1, 8'h14, 8'hff); check(err, 1);
    apb(0, 8'h14, 0); check(rd, 0); check(err, 1);
    apb(1, 8'h0c, 8'h80); apb(0, 8'h0c, 0); check(rd, 8'h80); check(port_enable, 1);
    for (i = 0; i < 6; i++) begin
      p = cfg[i][2] ? 4 : (cfg[i][1] && cfg[i][0]) ? 4 : (cfg[i][1] || cfg[i][0]) ? 16 : 64;
      p = p * (cfg[i][0] ? 259 : 3);
      apb(1, 8'h08, {3'b0, cfg[i][2], 1'b0, cfg[i][1], 2'b0});
      apb(1, 8'h10, {4'b0, cfg[i][0], 3'b0});
      apb(1, 8'h04, 8'h01);
      apb(1, 8'h00, 8'h02);
      check(sync_mode, cfg[i][2]);
      tick(); check(c >= p - 1 && c <= p + 1, 1);
      tick(); check(c, p);
    end
    rx_start <= 1;
    @(posedge clk);
    rx_start <= 0;
    repeat (4) @(posedge clk);
    apb(0, 8'h10, 0); check(rd[6], 0);
    do apb(0, 8'h10, 0); while (rd[6] !== 1'b1);
    check(rx_active, 0);
    report_and_stop();
  end
endmodule
`default_nettype wire

// ### verif/serial_far_end.sv
`timescale 1ns/10ps
`default_nettype none
module serial_far_end (
  input wire logic  clk,
  input wire logic  arst_n,
  input wire logic  rate_tick,
  input wire logic  rx_start,
  output logic      rx_active,
  output logic      tx_shift_empty
);
  logic [1:0] bits_r;
  // short frame: two rate ticks long
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) bits_r <= 2'h0;
    else if (rx_start) bits_r <= 2'h2;
    else if (rate_tick && bits_r != 2'h0) bits_r <= bits_r - 2'h1;
  end
  assign rx_active      = bits_r != 2'h0;
  assign tx_shift_empty = bits_r == 2'h0;
endmodule
`default_nettype wire
